// ===== shared/fcmp_pkg.sv
/*
 * constants and types shared by the flyback cycle sequencer modules.
 * assumes a single 40 MHz clock and a synchronous active-low reset.
 */
package fcmp_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int PERIOD_NS = 25_000;                  // nominal 40 kHz cycle
    localparam int PERIOD_CYC = PERIOD_NS * CYC_PER_US / 1000;
    localparam int MAX_PERIOD_NS = 75_000;              // longest stretched cycle
    localparam int MAX_PERIOD_CYC = MAX_PERIOD_NS * CYC_PER_US / 1000;
    localparam int MIN_RESET_INTERVAL_NS = 2_300;       // shortest demag interval
    localparam int MIN_RESET_INTERVAL_CYC = (MIN_RESET_INTERVAL_NS * CYC_PER_US + 999) / 1000;
    localparam int MIN_ON_TIME_NS = 500;                // below this go to pfm
    localparam int MIN_ON_TIME_CYC = (MIN_ON_TIME_NS * CYC_PER_US + 999) / 1000;
    localparam int SS_STEP_US = 1_000;                  // one soft-start step
    localparam int SS_STEP_CYC = SS_STEP_US * CYC_PER_US;
    localparam int TON_MAX_CYC = 400;                   // full on-time limit

    // ****************************************
    // protection and modulation figures
    // ****************************************
    localparam int FAULT_LIMIT = 6;                     // shut after more than this
    localparam int GND_LIMIT = 6;                       // shut after this many pulses
    localparam int LOAD_FULL = 255;                     // load code at rated current
    localparam int LOAD_PCT = 5;                        // pwm above this load
    localparam int LOAD_PFM_EXIT = LOAD_FULL * LOAD_PCT / 100;
    localparam int PFM_STRETCH = 7;                     // off-time cycles per load step
    localparam int PFM_VT_VUS = 185;                    // line volt times on-time cap
    localparam int PFM_VT_CAP = PFM_VT_VUS * CYC_PER_US;
    localparam int CABLE_MV = 300;                      // offset at full load

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic vin_uv;
        logic vin_ov;
        logic vs_uv;
        logic vs_ov;
        logic vsense;       // aux winding above its knee
    } fcmp_sense_t;

    typedef enum logic [1:0] {PH_IDLE, PH_ON, PH_OFF, PH_SHUT} fcmp_phase_t;

    typedef struct packed {
        fcmp_phase_t phase;
        logic [12:0] cnt;
        logic [12:0] ton;
        logic [12:0] period;
        logic [15:0] acc;
        logic pfm;
        logic gate;
        logic edge_seen;
        logic hi_seen;
        logic [6:0] hi_len;
        logic vs_prev;
        logic vin_bad;
        logic vs_bad;
        logic [2:0] vin_cnt;
        logic [2:0] vs_cnt;
        logic [2:0] gnd_cnt;
        logic [15:0] ss_cnt;
        logic [1:0] ss_step;
        logic ss_done;
    } fcmp_state_t;

endpackage

// ===== verilog/fcmp_sync.sv
/*
 * two-flop synchroniser for a group of pin levels.
 * assumes the inputs are levels that stay stable over several clocks.
 */
module fcmp_sync import fcmp_pkg::*; #(
    parameter int W = 1
) (
    input wire logic i_clk,             // system clock
    input wire logic i_reset_n,         // synchronous reset, active low
    input wire logic [W-1:0] i_async,   // raw pin levels
    output logic [W-1:0] o_sync         // synchronised levels
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fcmp_sync_st_t;

    fcmp_sync_st_t q, d;

    // first stage feeds only the second
    always_comb begin
        d.s1 = i_async;
        d.s2 = q.s1;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_sync = q.s2;

endmodule

// ===== verilog/fcmp_cable_comp.sv
/*
 * feedback offset proportional to load current.
 * assumes the variant strap is static and already synchronised.
 */
module fcmp_cable_comp import fcmp_pkg::*; (
    input wire logic i_clk,             // system clock
    input wire logic i_reset_n,         // synchronous reset, active low
    input wire logic i_strap,           // high selects the compensated variant
    input wire logic [7:0] i_load,      // detected load current
    input wire logic [11:0] i_fb,       // feedback value in mV
    output logic [12:0] o_fb            // compensated feedback in mV
);

    typedef struct packed {
        logic en;
        logic [12:0] fb;
    } fcmp_cc_st_t;

    fcmp_cc_st_t q, d;
    logic [16:0] prod;

    // offset scales with load, 300 mV at full load
    always_comb begin
        d = q;
        // follow the synchronised strap: the synchroniser reads low through reset
        d.en = i_strap;
        prod = 17'(17'(i_load) * 17'(CABLE_MV) / 17'(LOAD_FULL));
        if (q.en) begin
            d.fb = 13'(i_fb) + prod[12:0];
        end else begin
            d.fb = 13'(i_fb);
        end
    end

    // lockout clears the offset state; the strap level returns after release
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_fb = q.fb;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    no_offset_a: assert property (!q.en |=> o_fb == 13'($past(i_fb)))
        else $error("offset applied without compensation");
    full_offset_a: assert property (q.en && i_load == 8'(LOAD_FULL)
        |=> o_fb == 13'($past(i_fb)) + 13'(CABLE_MV))
        else $error("full load offset wrong");

endmodule

// ===== verilog/fcmp_cycle_top.sv
/*
 * switching cycle sequencer for a primary-side flyback controller.
 * assumes a 40 MHz clock, reset tied to supply undervoltage lockout,
 * sense comparators arriving as raw pins, and line, on-time, load and
 * feedback words produced by logic on the same clock.
 */
// Contract
// - nominal switching cycle is fixed at 40 kHz in pwm; pfm lengthens it as load falls
// - each cycle waits for aux falling edge, stretching past 25 us; a cycle where aux never rises ends at its period
// - stretched cycle reaching 75 us without edge stops switching
// - pwm at fixed frequency above 5% load, on-time follows load
// - on-time below minimum enters pfm; line sets on, load sets off
// - pfm returns to pwm by itself when load rises
// - line or aux out of range over 6 cycles stops switching
// - after fault, only supply lockout reset restarts with soft-start
// - aux sense at ground stops switching after 6 pulses
// - compensated variant adds load-scaled offset, 300 mV at full load
// - uncompensated variant adds no offset to feedback
// - pfm caps line voltage times on-time at 185 V us
// - demag intervals down to 2.3 us are detected
// - soft-start limits on-time to 25, 50, 75% for 1 ms each
// - supply lockout resets all control state
module fcmp_cycle_top import fcmp_pkg::*; #(
    parameter int SS_STEP = SS_STEP_CYC,            // soft-start step in cycles
    parameter int TON_MAX = TON_MAX_CYC,            // full on-time in cycles
    parameter int MIN_ON = MIN_ON_TIME_CYC          // pfm entry on-time
) (
    input wire logic i_clk,                     // 40 MHz clock
    input wire logic i_reset_n,                 // supply lockout, active low
    input wire fcmp_sense_t i_sense,            // comparator pins
    input wire logic i_cable_strap,             // variant strap pin
    input wire logic [9:0] i_vin_code,          // scaled line voltage, volts
    input wire logic [12:0] i_ton_cmd,          // loop on-time request, cycles
    input wire logic [7:0] i_load_code,         // detected load current
    input wire logic [11:0] i_fb_code,          // feedback value, mV
    output logic o_gate,                        // power switch gate drive
    output logic o_pfm,                         // pfm mode active
    output logic o_fault,                       // switching shut down
    output logic o_soft_start,                  // soft-start in progress
    output logic [12:0] o_fb_comp               // compensated feedback, mV
);

    // ****************************************
    // pin synchronisation and cable offset
    // ****************************************
    fcmp_sense_t s;
    logic strap_s;

    fcmp_sync #(.W(6)) u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_sense, i_cable_strap}),
        .o_sync({s, strap_s})
    );

    fcmp_cable_comp u_cable (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_strap(strap_s),
        .i_load(i_load_code),
        .i_fb(i_fb_code),
        .o_fb(o_fb_comp)
    );

    // ****************************************
    // cycle sequencer
    // ****************************************
    fcmp_state_t q, d;
    logic [12:0] ss_lim;
    logic vs_fall;
    logic [2:0] n_vin, n_vs, n_gnd;

    // start a new switching cycle, choosing mode, on-time and period
    function automatic fcmp_state_t launch(fcmp_state_t c, logic [12:0] lim);
        fcmp_state_t r;
        logic pfm;
        r = c;
        if (c.pfm) begin
            pfm = i_load_code <= 8'(LOAD_PFM_EXIT);
        end else begin
            pfm = i_ton_cmd < 13'(MIN_ON);
        end
        r.phase = PH_ON;
        r.cnt = '0;
        r.acc = '0;
        r.gate = 1'b1;
        r.edge_seen = 1'b0;
        r.hi_seen = 1'b0;
        r.hi_len = '0;
        r.vin_bad = 1'b0;
        r.vs_bad = 1'b0;
        r.pfm = pfm;
        if (pfm) begin
            // line sets on-time via the cap, load sets the off-time
            r.ton = lim;
            r.period = 13'(PERIOD_CYC) + 13'((8'(LOAD_FULL) - i_load_code) * PFM_STRETCH);
        end else begin
            // fixed period, on-time shrinks with load
            r.ton = (i_ton_cmd < lim) ? i_ton_cmd : lim;
            r.period = 13'(PERIOD_CYC);
        end
        if (r.ton == '0) begin
            r.ton = 13'd1;
        end
        return r;
    endfunction

    // soft-start on-time ceiling: quarter steps of the full on-time
    always_comb begin
        if (q.ss_done) begin
            ss_lim = 13'(TON_MAX);
        end else begin
            ss_lim = 13'(TON_MAX * (int'(q.ss_step) + 1) / 4);
        end
    end

    // qualified falling edge of the aux sense
    assign vs_fall = q.vs_prev && !s.vsense && q.hi_len >= 7'(MIN_RESET_INTERVAL_CYC);

    // next-cycle fault counts, cleared by a clean cycle
    always_comb begin
        n_vin = (q.vin_bad || s.vin_uv || s.vin_ov) ? q.vin_cnt + 3'd1 : 3'd0;
        n_vs = (q.vs_bad || s.vs_uv || s.vs_ov) ? q.vs_cnt + 3'd1 : 3'd0;
        n_gnd = (q.hi_seen || s.vsense) ? 3'd0 : q.gnd_cnt + 3'd1;
    end

    // main sequencer next state
    always_comb begin
        d = q;
        d.vs_prev = s.vsense;
        // soft-start stepping, frozen once switching is shut
        if (!q.ss_done && q.phase != PH_SHUT) begin
            if (q.ss_cnt == 16'(SS_STEP - 1)) begin
                d.ss_cnt = '0;
                d.ss_step = q.ss_step + 2'd1;
                d.ss_done = q.ss_step == 2'd2;
            end else begin
                d.ss_cnt = q.ss_cnt + 16'd1;
            end
        end
        if (q.phase == PH_ON || q.phase == PH_OFF) begin
            d.vin_bad = q.vin_bad || s.vin_uv || s.vin_ov;
            d.vs_bad = q.vs_bad || s.vs_uv || s.vs_ov;
        end
        unique case (q.phase)
            PH_IDLE: begin
                d = launch(d, ss_lim);
            end
            PH_ON: begin
                d.cnt = q.cnt + 13'd1;
                if (q.pfm) begin
                    d.acc = q.acc + 16'(i_vin_code);
                end
                // end the pulse on time, or on the volt-time cap in pfm
                if (d.cnt >= q.ton || (q.pfm && d.acc >= 16'(PFM_VT_CAP))) begin
                    d.phase = PH_OFF;
                    d.gate = 1'b0;
                    d.hi_len = '0;
                end
            end
            PH_OFF: begin
                d.cnt = q.cnt + 13'd1;
                if (s.vsense) begin
                    d.hi_seen = 1'b1;
                    if (q.hi_len != 7'h7f) begin
                        d.hi_len = q.hi_len + 7'd1;
                    end
                end else begin
                    d.hi_len = '0;
                end
                // demag end accepted once the high interval is long enough
                if (vs_fall) begin
                    d.edge_seen = 1'b1;
                end
                if (!d.edge_seen && d.cnt >= 13'(MAX_PERIOD_CYC)) begin
                    d.phase = PH_SHUT;
                    d.cnt = q.cnt;
                end else if (d.cnt >= q.period && (d.edge_seen || !d.hi_seen)) begin
                    // cycle over: book the faults, then shut or relaunch
                    d.vin_cnt = n_vin;
                    d.vs_cnt = n_vs;
                    d.gnd_cnt = n_gnd;
                    if (n_vin > 3'(FAULT_LIMIT) || n_vs > 3'(FAULT_LIMIT)) begin
                        d.phase = PH_SHUT;
                    end else if (n_gnd >= 3'(GND_LIMIT)) begin
                        d.phase = PH_SHUT;
                    end else begin
                        d = launch(d, ss_lim);
                    end
                end
            end
            PH_SHUT: begin
                // held until supply lockout resets the block
                d.gate = 1'b0;
            end
        endcase
    end

    // supply lockout clears everything
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            q <= '0;
            q.phase <= PH_IDLE;
        end else begin
            q <= d;
        end
    end

    assign o_gate = q.gate;
    assign o_pfm = q.pfm;
    assign o_fault = q.phase == PH_SHUT;
    assign o_soft_start = !q.ss_done;

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence cycle_launch;
        q.phase == PH_OFF ##1 q.phase == PH_ON && q.cnt == 13'd0;
    endsequence

    sequence rise_after_cycle;
        $rose(q.gate) && $past(q.phase) == PH_OFF;
    endsequence

    lockout_clear_a: assert property (disable iff (1'b0)
        !i_reset_n |=> q.phase == PH_IDLE && !q.gate && !q.ss_done)
        else $error("lockout did not clear state");
    shut_gate_low_a: assert property (q.phase == PH_SHUT |-> !q.gate ##1 !q.gate)
        else $error("gate driven while shut");
    shut_sticky_a: assert property (q.phase == PH_SHUT |=> q.phase == PH_SHUT)
        else $error("left shutdown without lockout");
    stretch_bound_a: assert property (q.phase != PH_SHUT |-> q.cnt < 13'(MAX_PERIOD_CYC))
        else $error("cycle ran past longest period");
    nominal_period_a: assert property (rise_after_cycle
        |-> $past(q.cnt) >= 13'(PERIOD_CYC - 1))
        else $error("cycle shorter than nominal period");
    soft_limit_a: assert property (q.gate && !q.ss_done |-> q.cnt < ss_lim)
        else $error("on-time above soft-start limit");
    pfm_cap_a: assert property (q.gate && q.pfm |-> q.acc < 16'(PFM_VT_CAP))
        else $error("pfm volt-time cap exceeded");
    vin_fault_a: assert property (q.vin_cnt > 3'(FAULT_LIMIT) |-> q.phase == PH_SHUT)
        else $error("line fault not shut down");
    gnd_fault_a: assert property (q.gnd_cnt >= 3'(GND_LIMIT) |-> q.phase == PH_SHUT)
        else $error("grounded aux not shut down");
    pfm_entry_a: assert property (cycle_launch ##0 !$past(q.pfm)
        && $past(i_ton_cmd) < 13'(MIN_ON) |-> q.pfm)
        else $error("pfm not entered at low on-time");
    pfm_leave_a: assert property (cycle_launch ##0 $past(q.pfm)
        && $past(i_load_code) > 8'(LOAD_PFM_EXIT) |-> !q.pfm)
        else $error("pfm not left at higher load");
    clean_clear_a: assert property (cycle_launch ##0 !$past(q.vin_bad)
        && !$past(s.vin_uv) && !$past(s.vin_ov) |-> q.vin_cnt == 3'd0)
        else $error("fault count kept after clean cycle");

endmodule

// ===== test/fcmp_aux_model.sv
/*
 * aux winding sense model: one demag pulse after each gate turn-off.
 * assumes the bench picks the mode and the pulse length.
 */
module fcmp_aux_model (
    input wire logic i_clk,             // system clock
    input wire logic i_gate,            // gate drive from the block
    input wire logic [1:0] i_mode,      // 0 normal, 1 grounded, 2 stuck high
    input wire logic [12:0] i_hi_len,   // demag length in cycles
    output logic o_vsense               // aux comparator level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic gate_q = 1'b0;
    logic stuck_q = 1'b0;
    logic [12:0] left_q = 13'h0000;
    // ****************************************
    // demag pulse
    // ****************************************
    // a pulse starts at each gate turn-off; stuck mode never ends it
    always @(posedge i_clk) begin
        gate_q <= i_gate;
        stuck_q <= (i_mode == 2'h2) && (stuck_q || (gate_q && !i_gate));
        if (gate_q && !i_gate) begin
            left_q <= i_hi_len;
        end else if (left_q != 13'h0000) begin
            left_q <= left_q - 13'h0001;
        end
    end
    // a grounded pin never rises
    assign o_vsense = (i_mode != 2'h1) && (stuck_q || left_q != 13'h0000);
endmodule

// ===== test/tb_flyback_cycle_mode_protect.sv
/*
 * self-checking bench for the flyback cycle sequencer.
 * assumes the aux model in fcmp_aux_model and a 40 MHz clock.
 */
module tb_flyback_cycle_mode_protect import fcmp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic strap = 1'b1;
    logic [3:0] bad = 4'h0;
    logic vs;
    logic [1:0] mode = 2'h0;
    logic [12:0] hi_len = 13'h0064;
    logic [9:0] vin = 10'h064;
    logic [12:0] ton = 13'h0064;
    logic [7:0] load = 8'hc8;
    logic [11:0] fb = 12'h000;
    logic o_gate, o_pfm, o_fault, o_ss;
    logic [12:0] o_fb;
    logic g_prev = 1'b0;
    int failures = 0;
    int total_checks = 0;
    int rises = 0;
    int falls = 0;
    int per_cnt = 0;
    int on_cnt = 0;
    int per_len, on_len, r0;
    time t0;

    fcmp_cycle_top #(.SS_STEP(50)) dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sense(fcmp_sense_t'({bad, vs})),
        .i_cable_strap(strap), .i_vin_code(vin), .i_ton_cmd(ton), .i_load_code(load),
        .i_fb_code(fb), .o_gate(o_gate), .o_pfm(o_pfm), .o_fault(o_fault),
        .o_soft_start(o_ss), .o_fb_comp(o_fb));
    fcmp_aux_model aux (.i_clk(i_clk), .i_gate(o_gate), .i_mode(mode),
        .i_hi_len(hi_len), .o_vsense(vs));

    always #12.5 i_clk = ~i_clk;

    // ****************************************
    // gate monitor and checks
    // ****************************************
    // on-time and launch-to-launch period, counted in clocks
    always @(negedge i_clk) begin
        if (o_gate === 1'b1 && !g_prev) begin
            per_len = per_cnt;
            per_cnt = 0;
            on_cnt = 0;
            rises++;
        end
        if (o_gate !== 1'b1 && g_prev) begin
            on_len = on_cnt;
            falls++;
        end
        per_cnt++;
        on_cnt += int'(o_gate === 1'b1);
        g_prev = (o_gate === 1'b1);
    end

    task chk_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s: got %b", $time, what, got);
        end
    endtask

    task chk_rng(input int got, input int lo, input int hi, input string what);
        total_checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("[ERR] %0t %s: got %0d not in %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    task chk_word(input logic [12:0] got, input logic [12:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [12:0] exp_fb(input logic s, input logic [11:0] f,
                                           input logic [7:0] l);
        return {1'b0, f} + (s ? 13'(int'(l) * 300 / 255) : 13'h0000);
    endfunction

    // bounded wait for the next gate rise or fall; stops on shutdown
    task automatic wait_edge(input bit fall, output bit ok);
        int r;
        r = fall ? falls : rises;
        ok = 1'b0;
        for (int i = 0; i < 4000 && !ok && o_fault !== 1'b1; i++) begin
            @(posedge i_clk);
            #1;
            ok = ((fall ? falls : rises) != r);
        end
    endtask

    task do_reset(input logic s, input logic [1:0] m);
        @(negedge i_clk);
        i_reset_n = 1'b0;
        strap = s;
        mode = m;
        bad = 4'h0;
        ton = 13'h0064;
        repeat (10) @(negedge i_clk);
        chk_bit(o_gate | o_pfm | o_fault, 1'b0, "reset outputs");
        chk_bit(o_ss, 1'b1, "reset soft start");
        chk_word(o_fb, 13'h0000, "reset feedback");
        i_reset_n = 1'b1;
        r0 = rises;
        t0 = $time;
    endtask

    task stop_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #2_500_000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        bit ok;
        int k;
        int v;
        void'($urandom(85013));
        do_reset(1'b1, 2'h0);
        ton = 13'h012c;
        @(posedge i_clk);
        #1;
        chk_bit(o_gate, 1'b1, "first launch");
        wait_edge(1, ok);
        chk_rng(on_len, 100, 100, "soft-start on-time");
        for (k = 0; k < 400 && o_ss === 1'b1; k++) begin
            @(posedge i_clk);
            #1;
        end
        chk_rng(int'(($time - t0) / 25), 147, 152, "soft-start length");
        wait_edge(0, ok);
        chk_rng(per_len, PERIOD_CYC, PERIOD_CYC, "first period");
        wait_edge(1, ok);
        chk_rng(on_len, 300, 300, "full on-time");
        $display("done: soft start");
        for (k = 0; k < 6; k++) begin
            @(negedge i_clk);
            ton = (k == 0) ? 13'h0014 : 13'($urandom_range(299, 21));
            hi_len = (k == 1) ? 13'h005c : 13'h0064;
            wait_edge(0, ok);
            chk_rng(per_len, PERIOD_CYC, PERIOD_CYC, "pwm period");
            chk_bit(o_pfm, 1'b0, "pwm mode");
            wait_edge(1, ok);
            chk_rng(on_len, int'(ton), int'(ton), "pwm on-time");
        end
        @(negedge i_clk);
        hi_len = 13'h05dc;
        ton = 13'h0064;
        wait_edge(0, ok);
        wait_edge(0, ok);
        chk_rng(per_len, 1600, 1608, "stretched period");
        @(negedge i_clk);
        hi_len = 13'h0064;
        mode = 2'h2;
        for (k = 0; k < 4000 && o_fault !== 1'b1; k++) begin
            @(posedge i_clk);
            #1;
        end
        chk_rng(per_cnt, 2998, 3004, "stretch limit");
        k = rises;
        @(negedge i_clk);
        mode = 2'h0;
        repeat (300) @(posedge i_clk);
        #1;
        chk_rng(rises - k, 0, 0, "no restart");
        chk_bit(o_gate, 1'b0, "gate held low");
        chk_bit(o_fault, 1'b1, "shutdown held");
        $display("done: pwm and stretch");
        do_reset(1'b1, 2'h1);
        for (k = 0; k < 12000 && o_fault !== 1'b1; k++) begin
            @(posedge i_clk);
            #1;
        end
        chk_rng(rises - r0, 6, 6, "grounded pulses");
        $display("done: grounded aux");
        for (v = 0; v < 4; v++) begin
            do_reset(1'b1, 2'h0);
            for (k = 0; k < 20; k++) begin
                wait_edge(0, ok);
                if (!ok) begin
                    break;
                end
                @(negedge i_clk);
                bad = (v == 0 && k == 6) ? 4'h0 : 4'h1 << v;
                wait_edge(1, ok);
                @(negedge i_clk);
                bad = 4'h0;
            end
            chk_rng(k, v == 0 ? 14 : 7, v == 0 ? 14 : 7, "bad cycles");
            chk_bit(o_gate, 1'b0, "gate in shutdown");
        end
        $display("done: range faults");
        do_reset(1'b1, 2'h0);
        wait_edge(0, ok);
        wait_edge(0, ok);
        @(negedge i_clk);
        load = 8'h04;
        ton = 13'h000a;
        for (k = 0; k < 3; k++) begin
            @(negedge i_clk);
            vin = 10'($urandom_range(400, 60));
            v = (7400 + int'(vin) - 1) / int'(vin);
            wait_edge(0, ok);
            if (k > 0) begin
                chk_rng(per_len, 2757, 2759, "pfm period");
            end
            chk_bit(o_pfm, 1'b1, "pfm entry");
            wait_edge(1, ok);
            chk_rng(on_len, v, v + 1, "pfm volt-time cap");
        end
        @(negedge i_clk);
        load = 8'hc8;
        ton = 13'h00c8;
        wait_edge(0, ok);
        chk_bit(o_pfm, 1'b0, "pfm exit");
        $display("done: pfm");
        for (v = 0; v < 2; v++) begin
            if (v == 1) begin
                do_reset(1'b0, 2'h0);
            end
            for (k = 0; k < 16; k++) begin
                @(negedge i_clk);
                fb = (k == 0) ? 12'hfff : 12'($urandom);
                load = (k == 0) ? 8'hff : 8'($urandom);
                @(negedge i_clk);
                chk_word(o_fb, exp_fb(strap, fb, load), "feedback offset");
            end
        end
        $display("done: feedback offset");
        stop_test();
    end
endmodule
